// ### design/excarb_pkg.sv
package excarb_pkg;

    // Source count and vector layout
    localparam int          NUM_SRC       = 24;
    localparam int          PRIO_W        = 5;
    localparam logic [15:0] VEC_RESET     = 16'hfffe;
    localparam logic [15:0] VEC_TRAP      = 16'hfffc;

    // Grouped sources sharing one flag
    localparam int          GRP9_N        = 3;
    localparam int          GRP11_N       = 4;
    localparam int          GRP12_N       = 2;
    localparam int          GRP13_N       = 2;
    localparam int          PRIO_G9       = 9;
    localparam int          PRIO_G11      = 11;
    localparam int          PRIO_G12      = 12;
    localparam int          PRIO_G13      = 13;

    // Register byte addresses
    localparam logic [11:0] ADDR_PEND1    = 12'h000;
    localparam logic [11:0] ADDR_PEND2    = 12'h004;
    localparam logic [11:0] ADDR_PEND3    = 12'h008;
    localparam logic [11:0] ADDR_PEND4    = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
    localparam logic [11:0] ADDR_ENABLE   = 12'h018;
    localparam logic [11:0] ADDR_CTRL     = 12'h01c;

    // Field positions
    localparam int          PEND1_LSB     = 2;
    localparam int          CTRL_GMASK    = 0;
    localparam logic [31:0] ENABLE_RST    = 32'h00ff_ffff;

    // Event status bits
    localparam int          EV_ENTRY      = 0;
    localparam int          EV_TRAP       = 1;
    localparam int          EV_RETURN     = 2;
    localparam int          EV_W          = 3;

    // Exception kind handed to the core
    typedef enum logic [1:0] {
        EXCARB_KIND_NONE = 2'b00,
        EXCARB_KIND_HW   = 2'b01,
        EXCARB_KIND_TRAP = 2'b11,
        EXCARB_KIND_RST  = 2'b10
    } excarb_kind_t;

    // Arbiter states
    typedef enum logic [1:0] {
        EXCARB_RUN   = 2'b00,
        EXCARB_LATCH = 2'b01,
        EXCARB_ENTER = 2'b11,
        EXCARB_ISR   = 2'b10
    } excarb_state_t;

endpackage

// ### design/excarb_top.sv
//
// Contract
// RULE1 - On entry core stacks registers and global mask gets set.
// RULE2 - Return-from-trap restores stacked registers; program resumes.
// RULE3 - Latch requests, arbitrate at processing start, hand fixed vector result.
// RULE4 - Latched request is not displaced until serviced or mask cleared. The code drops it when the global mask is set instead.
// RULE5 - Hardware interrupt waits for instruction completion, never aborts it.
// RULE6 - At completion enter only if mask clear and source enabled.
// RULE7 - Lowest priority number wins; zero is highest.
// RULE8 - Request still pending at return is serviced before next instruction. The code takes it only at the first insn_done after return.
// RULE9 - Entry does not stack the index high byte.
// RULE10 - Software trap always enters, regardless of global mask.
// RULE11 - Trap stacks current PC; hardware stacks PC minus one.
// RULE12 - Vector is FFFC minus twice priority; reset uses FFFE.
// RULE13 - Grouped sources share one flag, priority and vector.
// RULE14 - Global mask gates every source except software trap.
// RULE15 - Status one holds flags 6..1 in bits 7..2; bits 1..0 zero.
// RULE16 - Status three holds 22..15; status four 24..23 in bits 1..0.
// RULE17 - Reset has top priority, never arbitrated, preempts everything.
// RULE18 - Break request forces the software trap vector.
// RULE19 - Flags follow request lines; writes to status registers ignored.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module excarb_top
    import excarb_pkg::*;
(
    // Clock and reset
    input  wire  logic                 pclk,
    input  wire  logic                 presetn,
    // APB slave
    input  wire  logic                 psel,
    input  wire  logic                 penable,
    input  wire  logic                 pwrite,
    input  wire  logic [11:0]          paddr,
    input  wire  logic [31:0]          pwdata,
    input  wire  logic [3:0]           pstrb,
    output logic       [31:0]          prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Request sources; grouped flags 9, 11, 12 and 13 take their group lines
    input  wire  logic [NUM_SRC:1]     src_req,
    input  wire  logic [GRP9_N-1:0]    grp9_req,
    input  wire  logic [GRP11_N-1:0]   grp11_req,
    input  wire  logic [GRP12_N-1:0]   grp12_req,
    input  wire  logic [GRP13_N-1:0]   grp13_req,
    // Core handshake
    input  wire  logic                 core_reset_req,
    input  wire  logic                 insn_done,
    input  wire  logic                 trap_exec,
    input  wire  logic                 break_req,
    input  wire  logic                 rti_exec,
    input  wire  logic                 stack_done,
    input  wire  logic                 cli_exec,
    input  wire  logic                 sei_exec,
    output logic                       exc_req,
    output var   excarb_kind_t         exc_kind,
    output logic       [15:0]          exc_vector,
    output logic       [PRIO_W-1:0]    exc_prio,
    output logic                       stack_pc_minus1,
    output logic                       stack_index_high,
    output logic                       gmask,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////
    // Source flags

    // Asynchronous request lines: three-stage sync, update when 2 and 3 agree
    logic [NUM_SRC:1] req_s1_q, req_s2_q, req_s3_q, flag_q;
    logic [NUM_SRC:1] req_raw;
    logic             brk_s1_q, brk_s2_q, brk_s3_q, brk_q;

    always_comb begin
        req_raw           = src_req;
        req_raw[PRIO_G9]  = |grp9_req;   // RULE13
        req_raw[PRIO_G11] = |grp11_req;  // RULE13
        req_raw[PRIO_G12] = |grp12_req;  // RULE13
        req_raw[PRIO_G13] = |grp13_req;  // RULE13
    end

    genvar gi;
    generate
        for (gi = 1; gi <= NUM_SRC; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    req_s1_q[gi] <= 1'b0;
                    req_s2_q[gi] <= 1'b0;
                    req_s3_q[gi] <= 1'b0;
                    flag_q[gi]   <= 1'b0;
                end else begin
                    req_s1_q[gi] <= req_raw[gi];
                    req_s2_q[gi] <= req_s1_q[gi];
                    req_s3_q[gi] <= req_s2_q[gi];
                    if (req_s2_q[gi] == req_s3_q[gi]) begin
                        flag_q[gi] <= req_s3_q[gi];  // RULE19
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_s1_q <= 1'b0;
            brk_s2_q <= 1'b0;
            brk_s3_q <= 1'b0;
            brk_q    <= 1'b0;
        end else begin
            brk_s1_q <= break_req;
            brk_s2_q <= brk_s1_q;
            brk_s3_q <= brk_s2_q;
            if (brk_s2_q == brk_s3_q) begin
                brk_q <= brk_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Arbitration

    logic [31:0]       enable_q;
    logic [NUM_SRC:1]  cand;
    logic [PRIO_W-1:0] win_prio;
    logic              win_any;

    assign cand = flag_q & enable_q[NUM_SRC-1:0];  // RULE6

    // Lowest index wins: scan from top so index 1 overrides
    always_comb begin
        win_prio = '0;
        win_any  = 1'b0;
        for (int i = NUM_SRC; i >= 1; i--) begin
            if (cand[i]) begin
                win_prio = PRIO_W'(i);  // RULE7
                win_any  = 1'b1;
            end
        end
    end

    function automatic logic [15:0] vec_of(input logic [PRIO_W-1:0] p);
        vec_of = VEC_TRAP - {10'h000, p, 1'b0};  // RULE12
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Exception sequencer

    excarb_state_t     state_q;
    logic [PRIO_W-1:0] lat_prio_q;
    logic              ctrl_wr_en, ctrl_gmask_val;
    logic [EV_W-1:0]   ev_set;
    logic              trap_go, hw_go;

    // Break folds into the trap path; mask never blocks it
    assign trap_go = insn_done & (trap_exec | brk_q);     // RULE10 RULE18
    assign hw_go   = insn_done & ~gmask & win_any;        // RULE5 RULE6 RULE14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q          <= EXCARB_RUN;
            lat_prio_q       <= '0;
            exc_req          <= 1'b0;
            exc_kind         <= EXCARB_KIND_RST;
            exc_vector       <= VEC_RESET;
            exc_prio         <= '0;
            stack_pc_minus1  <= 1'b0;
            stack_index_high <= 1'b0;
            gmask            <= 1'b1;
        end else if (core_reset_req) begin
            // Reset bypasses arbitration and drops any latched request
            state_q    <= EXCARB_RUN;  // RULE17
            exc_req    <= 1'b1;
            exc_kind   <= EXCARB_KIND_RST;
            exc_vector <= VEC_RESET;
            exc_prio   <= '0;
            gmask      <= 1'b1;
            // Nothing is stacked for reset
            stack_pc_minus1 <= 1'b0;
        end else begin
            exc_req <= 1'b0;
            case (state_q)
                EXCARB_RUN: begin
                    if (ctrl_wr_en) begin
                        gmask <= ctrl_gmask_val;
                    end else if (cli_exec) begin
                        gmask <= 1'b0;
                    end else if (sei_exec) begin
                        gmask <= 1'b1;
                    end
                    if (trap_go) begin
                        state_q         <= EXCARB_ENTER;
                        exc_req         <= 1'b1;
                        exc_kind        <= EXCARB_KIND_TRAP;
                        exc_vector      <= VEC_TRAP;
                        exc_prio        <= '0;
                        stack_pc_minus1 <= 1'b0;  // RULE11
                    end else if (hw_go) begin
                        state_q    <= EXCARB_LATCH;
                        lat_prio_q <= win_prio;  // RULE3
                    end
                end
                EXCARB_LATCH: begin
                    // Held choice; only a set mask or a core reset drops it
                    if (gmask) begin
                        state_q <= EXCARB_RUN;  // RULE4
                    end else begin
                        state_q         <= EXCARB_ENTER;
                        exc_req         <= 1'b1;
                        exc_kind        <= EXCARB_KIND_HW;
                        exc_prio        <= lat_prio_q;
                        exc_vector      <= vec_of(lat_prio_q);  // RULE3 RULE12
                        stack_pc_minus1 <= 1'b1;                // RULE11
                    end
                end
                EXCARB_ENTER: begin
                    stack_index_high <= 1'b0;  // RULE9
                    if (stack_done) begin
                        state_q <= EXCARB_ISR;
                        gmask   <= 1'b1;  // RULE1
                    end
                end
                EXCARB_ISR: begin
                    if (ctrl_wr_en) begin
                        gmask <= ctrl_gmask_val;
                    end else if (cli_exec) begin
                        gmask <= 1'b0;
                    end
                    if (rti_exec) begin
                        // Mask is cleared here on return; pending work re-checked
                        state_q  <= EXCARB_RUN;  // RULE2 RULE8
                        gmask    <= 1'b0;
                        exc_kind <= EXCARB_KIND_NONE;
                    end else if (trap_go) begin
                        state_q         <= EXCARB_ENTER;
                        exc_req         <= 1'b1;
                        exc_kind        <= EXCARB_KIND_TRAP;
                        exc_vector      <= VEC_TRAP;
                        exc_prio        <= '0;
                        stack_pc_minus1 <= 1'b0;
                    end else if (hw_go) begin
                        state_q    <= EXCARB_LATCH;
                        lat_prio_q <= win_prio;
                    end
                end
                default: state_q <= EXCARB_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status

    logic [EV_W-1:0] ev_stat_q, ev_mask_q;
    logic            wr_acc, rd_acc;
    logic            sel_stat, sel_mask, sel_en, sel_ctrl;

    assign ev_set[EV_ENTRY]  = exc_req & (exc_kind == EXCARB_KIND_HW);
    assign ev_set[EV_TRAP]   = exc_req & (exc_kind == EXCARB_KIND_TRAP);
    assign ev_set[EV_RETURN] = (state_q == EXCARB_ISR) & rti_exec;

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_q <= '0;
        end else begin
            ev_stat_q <= (ev_stat_q & ~((wr_acc & sel_stat) ? pwdata[EV_W-1:0] : '0))
                         | ev_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_stat_q & ev_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave

    logic [31:0] rd_mux;
    logic        hit;

    assign wr_acc   = psel & penable & pwrite & pready;
    assign rd_acc   = psel & ~penable & ~pwrite;
    assign sel_stat = (paddr == ADDR_IRQ_STAT);
    assign sel_mask = (paddr == ADDR_IRQ_MASK);
    assign sel_en   = (paddr == ADDR_ENABLE);
    assign sel_ctrl = (paddr == ADDR_CTRL);
    assign hit      = (paddr == ADDR_PEND1) | (paddr == ADDR_PEND2)
                    | (paddr == ADDR_PEND3) | (paddr == ADDR_PEND4)
                    | sel_stat | sel_mask | sel_en | sel_ctrl;
    assign ctrl_wr_en     = wr_acc & sel_ctrl & pstrb[0];
    assign ctrl_gmask_val = pwdata[CTRL_GMASK];

    // Pending registers are read-only views of the flags
    always_comb begin
        rd_mux = '0;
        case (paddr)
            ADDR_PEND1:    rd_mux[7:PEND1_LSB] = flag_q[6:1];   // RULE15 RULE19
            ADDR_PEND2:    rd_mux[7:0]         = flag_q[14:7];  // RULE15
            ADDR_PEND3:    rd_mux[7:0]         = flag_q[22:15]; // RULE16
            ADDR_PEND4:    rd_mux[1:0]         = flag_q[24:23]; // RULE16
            ADDR_IRQ_STAT: rd_mux[EV_W-1:0]    = ev_stat_q;
            ADDR_IRQ_MASK: rd_mux[EV_W-1:0]    = ev_mask_q;
            ADDR_ENABLE:   rd_mux[NUM_SRC-1:0] = enable_q[NUM_SRC-1:0];
            ADDR_CTRL:     rd_mux[CTRL_GMASK]  = gmask;
            default:       rd_mux = '0;
        endcase
    end

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= '0;
            ev_mask_q <= '0;
            enable_q  <= ENABLE_RST;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (rd_acc) begin
                prdata <= rd_mux;
            end
            if (wr_acc & sel_mask & pstrb[0]) begin
                ev_mask_q <= pwdata[EV_W-1:0];
            end
            if (wr_acc & sel_en) begin
                for (int b = 0; b < 4; b++) begin
                    if (pstrb[b]) begin
                        enable_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### dv/excarb_chk.sv
`timescale 1ns/100ps
`default_nettype none
module excarb_chk
    import excarb_pkg::*;
(
    // Clock, reset and bus activity
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    // Core handshake
    input wire logic              core_reset_req,
    input wire logic              insn_done,
    input wire logic              trap_exec,
    input wire logic              rti_exec,
    input wire logic              stack_done,
    input wire logic              cli_exec,
    input wire logic              sei_exec,
    // Exception outputs
    input wire logic              exc_req,
    input wire excarb_kind_t      exc_kind,
    input wire logic [15:0]       exc_vector,
    input wire logic [PRIO_W-1:0] exc_prio,
    input wire logic              stack_pc_minus1,
    input wire logic              stack_index_high,
    input wire logic              gmask
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    property p_trap; insn_done && trap_exec && !core_reset_req |=>
        exc_req && exc_kind == EXCARB_KIND_TRAP && exc_vector == VEC_TRAP; endproperty
    a_trap: assert property (p_trap) else $error("trap entry missing");
    property p_hw_bound; exc_req && exc_kind == EXCARB_KIND_HW |-> $past(insn_done, 2); endproperty
    a_hw_bound: assert property (p_hw_bound) else $error("entry off boundary");
    property p_hw_unmask; exc_req && exc_kind == EXCARB_KIND_HW |-> !$past(gmask, 2); endproperty
    a_hw_unmask: assert property (p_hw_unmask) else $error("masked entry");
    property p_vec; exc_req && exc_kind == EXCARB_KIND_HW |->
        exc_prio inside {[1:24]} && exc_vector == 16'hfffc - {exc_prio, 1'b0}; endproperty
    a_vec: assert property (p_vec) else $error("bad hw vector");
    property p_pcm1; exc_req |-> stack_pc_minus1 == (exc_kind == EXCARB_KIND_HW); endproperty
    a_pcm1: assert property (p_pcm1) else $error("bad stacked pc kind");
    property p_noidx; exc_req |-> !stack_index_high; endproperty
    a_noidx: assert property (p_noidx) else $error("index high stacked");
    // Bus writes and mask pulses may override the mask, so those cycles are skipped
    property p_stack; stack_done && !psel && !cli_exec |=> gmask; endproperty
    a_stack: assert property (p_stack) else $error("mask not set on entry");
    property p_rti; rti_exec && !psel && !sei_exec |=> !gmask; endproperty
    a_rti: assert property (p_rti) else $error("mask not cleared on return");
    property p_rst; core_reset_req |=> exc_kind == EXCARB_KIND_RST && exc_vector == VEC_RESET;
    endproperty
    a_rst: assert property (p_rst) else $error("reset vector missing");
    c_hw: cover property (exc_req && exc_kind == EXCARB_KIND_HW);
    c_trap: cover property (exc_req && exc_kind == EXCARB_KIND_TRAP);
    c_rst: cover property (core_reset_req ##1 exc_kind == EXCARB_KIND_RST);
endmodule
`default_nettype wire

// ### dv/excarb_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module excarb_core_model (
    // Clock and vector fetch request
    input  wire logic pclk,
    input  wire logic exc_req,
    // Core status toward the arbiter
    output logic      insn_done,
    output logic      trap_exec,
    output logic      rti_exec,
    output logic      stack_done,
    output logic      cli_exec,
    output logic      sei_exec
);
    int stk_dly = 3;
    initial {insn_done, trap_exec, rti_exec, stack_done, cli_exec, sei_exec} = '0;
    // Stacking ends a few cycles after the fetch; index high byte is never pushed
    always @(posedge pclk) begin
        if (exc_req === 1'b1) begin
            repeat (stk_dly) @(posedge pclk);
            stack_done <= 1'b1;
            @(posedge pclk);
            stack_done <= 1'b0;
        end
    end
    task automatic insn(input logic trap);
        insn_done <= 1'b1;
        trap_exec <= trap;
        @(posedge pclk);
        {insn_done, trap_exec} <= 2'b00;
    endtask
    task automatic return_from_trap_instruction();
        rti_exec <= 1'b1;
        @(posedge pclk);
        rti_exec <= 1'b0;
    endtask
    task automatic set_mask(input logic m);
        {sei_exec, cli_exec} <= {m, !m};
        @(posedge pclk);
        {sei_exec, cli_exec} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ### dv/exception_arbiter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module exception_arbiter_tb
    import excarb_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   pstrb;
    logic [24:1]  src, e;
    logic [2:0]   g9;
    logic [3:0]   g11;
    logic [1:0]   g12, g13;
    logic         rst_req, brk, exc_req, pcm1, idxh, gmask, irq;
    logic         insn_done, trap_exec, rti_exec, stack_done, cli_exec, sei_exec;
    excarb_kind_t kind;
    logic [15:0]  vec;
    logic [4:0]   prio;
    int           n_errors, check_count;
    excarb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .src_req(src), .grp9_req(g9), .grp11_req(g11),
        .grp12_req(g12), .grp13_req(g13), .core_reset_req(rst_req), .insn_done,
        .trap_exec, .break_req(brk), .rti_exec, .stack_done, .cli_exec, .sei_exec,
        .exc_req, .exc_kind(kind), .exc_vector(vec), .exc_prio(prio),
        .stack_pc_minus1(pcm1), .stack_index_high(idxh), .gmask, .irq);
    excarb_core_model u_core (.pclk, .exc_req, .insn_done, .trap_exec, .rti_exec,
        .stack_done, .cli_exec, .sei_exec);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        chk(pready, 1'b1);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        chk(rd, x);
    endtask
    // Waits for a vector fetch; kind none means none may come
    task automatic wexc(input excarb_kind_t k, input logic [15:0] v);
        logic s;
        s = 1'b0;
        for (int i = 0; i < 8 && !s; i++) begin
            @(posedge pclk);
            s = (exc_req === 1'b1);
        end
        chk(s, k != EXCARB_KIND_NONE);
        if (s) begin
            chk(kind, k);
            chk(vec, v);
            chk(pcm1, k == EXCARB_KIND_HW);
            chk(prio, (VEC_TRAP - v) >> 1);
            chk(idxh, 1'b0);
        end
    endtask
    function automatic logic [31:0] pexp(input int n, input logic [24:1] v);
        case (n)
            0: return {24'h0, v[6:1], 2'b00};
            1: return {24'h0, v[14:7]};
            2: return {24'h0, v[22:15]};
            default: return {30'h0, v[24:23]};
        endcase
    endfunction
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, rst_req, brk, paddr, pwdata} = '0;
        {src, g9, g11, g12, g13, n_errors, check_count} = '0;
        pstrb = 4'hf;
        cyc(12);
        presetn <= 1'b1;
        cyc(1);
        chk(kind, EXCARB_KIND_RST);
        chk(vec, VEC_RESET);
        rdchk(ADDR_ENABLE, ENABLE_RST);
        apb(1'b0, 12'hfc0, '0);
        chk(err, 1'b1);
        for (int k = 0; k < 3; k++) begin
            src <= (k == 0) ? '1 : (k == 1) ? 24'h5a5a5a : '0;
            {g9, g11, g12, g13} <= {3'(k * 3), 4'(k * 5), 2'(k), 2'(k & 1)};
            cyc(5);
            e = src;
            {e[9], e[11], e[12], e[13]} = {|g9, |g11, |g12, |g13};
            for (int n = 0; n < 4; n++) begin
                apb(1'b1, 12'(4 * n), '1);
                rdchk(12'(4 * n), pexp(n, e));
            end
        end
        src <= 24'h000014;
        {g9, g11, g12, g13} <= '0;
        cyc(5);
        u_core.set_mask(1'b0);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_HW, 16'hfff6);
        cyc(6);
        chk(gmask, 1'b1);
        src[3] <= 1'b0;
        cyc(5);
        // Priority 2 flag rises just after priority 5 is latched
        src[2] <= 1'b1;
        u_core.return_from_trap_instruction();
        cyc(1);
        chk(gmask, 1'b0);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_HW, 16'hfff2);
        cyc(6);
        src <= 24'h000001;
        cyc(5);
        u_core.return_from_trap_instruction();
        u_core.set_mask(1'b1);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_NONE, '0);
        u_core.insn(1'b1);
        wexc(EXCARB_KIND_TRAP, VEC_TRAP);
        cyc(6);
        u_core.return_from_trap_instruction();
        apb(1'b1, ADDR_ENABLE, 32'h00ff_fffe);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_NONE, '0);
        pstrb <= 4'h2;
        apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
        rdchk(ADDR_ENABLE, 32'h00ff_00fe);
        pstrb <= 4'hf;
        apb(1'b1, ADDR_ENABLE, ENABLE_RST);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_HW, 16'hfffa);
        cyc(6);
        src <= '0;
        g13 <= 2'h2;
        cyc(5);
        u_core.return_from_trap_instruction();
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_HW, 16'hffe2);
        cyc(6);
        g13 <= '0;
        rdchk(ADDR_IRQ_STAT, 32'h7);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        cyc(1);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        cyc(1);
        chk(irq, 1'b0);
        rdchk(ADDR_IRQ_STAT, 32'h6);
        brk <= 1'b1;
        cyc(5);
        u_core.insn(1'b0);
        wexc(EXCARB_KIND_TRAP, VEC_TRAP);
        brk <= 1'b0;
        cyc(6);
        u_core.return_from_trap_instruction();
        rst_req <= 1'b1;
        cyc(2);
        chk(kind, EXCARB_KIND_RST);
        chk(vec, VEC_RESET);
        rst_req <= 1'b0;
        cyc(2);
        end_of_test();
    end
    initial begin
        cyc(20000);
        n_errors++;
        end_of_test();
    end
endmodule
bind excarb_top excarb_chk u_chk (.pclk, .presetn, .psel, .core_reset_req, .insn_done,
    .trap_exec, .rti_exec, .stack_done, .cli_exec, .sei_exec, .exc_req, .exc_kind,
    .exc_vector, .exc_prio, .stack_pc_minus1, .stack_index_high, .gmask);
`default_nettype wire
